// File: rtl/multiphase_pwm_power_state_ctrl.sv
// Multiphase pwm generation, power-state and output-good control
`timescale 1ns/1ps
module multiphase_pwm_power_state_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Enable and straps (asynchronous pins)
  input wire logic enable,
  input wire logic third_sense_neg,
  input wire logic ramp_strap,
  input wire logic [11:0] frequency_strap,
  // Variant option: diode emulation with drive reduction in low power
  input wire logic dem_variant,
  // Processor power-state pins
  input wire logic power_state_low_n,
  input wire logic host_reset_n,
  // Regulation status from analog side
  input wire logic soft_start_done,
  input wire logic ref_transition,
  input wire logic voltage_in_window,
  input wire logic overcurrent,
  // Modulator comparators per phase and fast-align trip
  input wire logic [2:0] error_above_ramp,
  input wire logic [2:0] zero_current,
  input wire logic fast_align_input,
  // Gate commands
  output logic [2:0] high_side_gate,
  output logic [2:0] low_side_gate,
  // Low-side supply: reduce in low power with dem_variant; high picks 7.75V over 5.75V
  output logic low_side_supply_reduce,
  output logic low_side_supply_high,
  // Output good, open drain
  output logic output_good_out,
  output logic output_good_oe,
  // Status
  output logic low_power_active,
  output logic [1:0] active_phases
);
  localparam int NS = 6;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic en_s, tsn_s, rs_s, psl_s, hrn_s, fa_s;
  logic [2:0] eab_s;
  logic [2:0] zc_s;
  logic [2:0] eab_1, eab_2, zc_1, zc_2;
  logic [11:0] fs_1, fs_2;
  logic [21:0] holdoff;
  logic holdoff_done;
  logic [21:0] good_cnt;
  logic good_fault;
  logic low_allowed;
  pwm_ctrl_pkg::power_state_t state;
  logic [2:0] start;
  logic [2:0] pulse;
  logic [2:0] fired;
  logic [2:0] dem_off;
  logic [2:0] phase_en;
  logic [11:0] period;

  // Two-stage synchronisers for all pins except dem_variant and the regulation status inputs
  always_ff @(posedge clk) begin
    sync1 <= {enable, third_sense_neg, ramp_strap, power_state_low_n,
              host_reset_n, fast_align_input};
    sync2 <= sync1;
    eab_1 <= error_above_ramp;
    eab_2 <= eab_1;
    zc_1 <= zero_current;
    zc_2 <= zc_1;
    fs_1 <= frequency_strap;
    fs_2 <= fs_1;
  end
  assign en_s = sync2[5];
  assign tsn_s = sync2[4];
  assign rs_s = sync2[3];
  assign psl_s = sync2[2];
  assign hrn_s = sync2[1];
  assign fa_s = sync2[0];
  assign eab_s = eab_2;
  assign zc_s = zc_2;
  assign period = (fs_2 < pwm_ctrl_pkg::PERIOD_MIN) ?
                  pwm_ctrl_pkg::PERIOD_MIN : fs_2;

  // Phase count: strap picks two phases
  always_ff @(posedge clk) begin
    if (srst) begin
      active_phases <= pwm_ctrl_pkg::PHASE_CNT_3;
    end else if (!en_s) begin
      active_phases <= tsn_s ? pwm_ctrl_pkg::PHASE_CNT_2 :
                       pwm_ctrl_pkg::PHASE_CNT_3;
    end
  end

  // Hold-off only after a host reset was seen low, not at power-up
  always_ff @(posedge clk) begin
    if (srst) begin
      holdoff <= 22'h000000;
      holdoff_done <= 1'b1;
    end else begin
      if (!hrn_s) begin
        holdoff <= 22'h000000;
        holdoff_done <= 1'b0;
      end else if (!holdoff_done) begin
        if (holdoff == 22'(pwm_ctrl_pkg::HOLDOFF_CYCLES - 1)) begin
          holdoff_done <= 1'b1;
        end else begin
          holdoff <= holdoff + 22'h000001;
        end
      end
    end
  end

  // Soft-start and reference moves force normal state
  assign low_allowed = hrn_s && holdoff_done &&
                       soft_start_done && !ref_transition;

  // Power state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= pwm_ctrl_pkg::ST_OFF;
    end else begin
      case (state)
        pwm_ctrl_pkg::ST_OFF: begin
          if (en_s) begin
            state <= pwm_ctrl_pkg::ST_NORMAL;
          end
        end
        pwm_ctrl_pkg::ST_NORMAL: begin
          if (!en_s) begin
            state <= pwm_ctrl_pkg::ST_OFF;
          end else if (!psl_s && low_allowed) begin
            state <= pwm_ctrl_pkg::ST_LOW;
          end
        end
        pwm_ctrl_pkg::ST_LOW: begin
          if (!en_s) begin
            state <= pwm_ctrl_pkg::ST_OFF;
          end else if (psl_s || !low_allowed) begin
            state <= pwm_ctrl_pkg::ST_NORMAL;
          end
        end
        default: state <= pwm_ctrl_pkg::ST_OFF;
      endcase
    end
  end

  assign low_power_active = (state == pwm_ctrl_pkg::ST_LOW);
  assign phase_en = low_power_active ? 3'h1 :
                    (state == pwm_ctrl_pkg::ST_NORMAL) ?
                    ((active_phases == pwm_ctrl_pkg::PHASE_CNT_3) ?
                     3'h7 : 3'h3) : 3'h0;

  phase_timer u_timer (
    .clk(clk),
    .srst(srst),
    .run(state != pwm_ctrl_pkg::ST_OFF),
    .period(period),
    .phases(active_phases),
    .start(start)
  );

  // Modulator: one rise per interval unless fast-align trips, fall at next crossing
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse <= 3'h0;
      fired <= 3'h0;
      dem_off <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!phase_en[i]) begin
          pulse[i] <= 1'b0;
          fired[i] <= 1'b0;
          dem_off[i] <= 1'b0;
        end else begin
          if (start[i]) begin
            fired[i] <= 1'b0;
            dem_off[i] <= 1'b0;
          end
          if (pulse[i]) begin
            if (!eab_s[i] && !fa_s) begin
              pulse[i] <= 1'b0;
            end
          end else if (fa_s ||
                       (eab_s[i] && (!fired[i] || start[i]))) begin
            pulse[i] <= 1'b1;
            fired[i] <= 1'b1;
          end
          if (low_power_active && dem_variant && zc_s[i] &&
              !pulse[i]) begin
            dem_off[i] <= 1'b1;
          end
        end
      end
    end
  end

  // Gate drive from pulse state
  always_ff @(posedge clk) begin
    if (srst) begin
      high_side_gate <= 3'h0;
      low_side_gate <= 3'h0;
    end else begin
      high_side_gate <= pulse & phase_en;
      low_side_gate <= ~pulse & phase_en & ~dem_off;
    end
  end

  // Low-side supply reduction and level choice
  always_ff @(posedge clk) begin
    if (srst) begin
      low_side_supply_reduce <= 1'b0;
      low_side_supply_high <= 1'b0;
    end else begin
      low_side_supply_reduce <= low_power_active && dem_variant;
      low_side_supply_high <= rs_s;
    end
  end

  // Output good: delay from soft-start end, window good
  assign good_fault = !en_s || !voltage_in_window || overcurrent ||
                      !soft_start_done;
  always_ff @(posedge clk) begin
    if (srst || good_fault) begin
      good_cnt <= 22'h000000;
      output_good_oe <= 1'b1;
    end else if (good_cnt ==
                 22'(pwm_ctrl_pkg::GOOD_DELAY_CYCLES - 1)) begin
      output_good_oe <= 1'b0;
    end else begin
      good_cnt <= good_cnt + 22'h000001;
    end
  end
  assign output_good_out = 1'b0;

  // Checks
  property p_good_low_before_ss;
    @(posedge clk) disable iff (srst) !soft_start_done |=> output_good_oe;
  endproperty
  a_good_low_before_ss: assert property (p_good_low_before_ss)
    else $error("output good released before soft-start end");

  property p_good_fault;
    @(posedge clk) disable iff (srst) overcurrent |=> output_good_oe;
  endproperty
  a_good_fault: assert property (p_good_fault)
    else $error("output good released during overcurrent");

  property p_reset_no_low;
    @(posedge clk) disable iff (srst) !hrn_s |=> !low_power_active;
  endproperty
  a_reset_no_low: assert property (p_reset_no_low)
    else $error("low power entered while host reset low");

  property p_softstart_normal;
    @(posedge clk) disable iff (srst)
      (ref_transition || !soft_start_done) |=> !low_power_active;
  endproperty
  a_softstart_normal: assert property (p_softstart_normal)
    else $error("low power during soft-start or reference move");

  property p_low_one_phase;
    @(posedge clk) disable iff (srst)
      low_power_active |=> (high_side_gate[2:1] == 2'h0);
  endproperty
  a_low_one_phase: assert property (p_low_one_phase)
    else $error("extra phase switching in low power");

  property p_one_rise;
    @(posedge clk) disable iff (srst)
      (fired[0] && !start[0] && !fa_s) |=> !$rose(pulse[0]);
  endproperty
  a_one_rise: assert property (p_one_rise)
    else $error("second rising edge in one interval");

  property p_gates_exclusive;
    @(posedge clk) disable iff (srst) (high_side_gate & low_side_gate) == 3'h0;
  endproperty
  a_gates_exclusive: assert property (p_gates_exclusive)
    else $error("both gates on");

  property p_two_phase;
    @(posedge clk) disable iff (srst)
      (active_phases == pwm_ctrl_pkg::PHASE_CNT_2) |=> !high_side_gate[2];
  endproperty
  a_two_phase: assert property (p_two_phase)
    else $error("phase 3 switching in two-phase mode");

  property p_disabled_off;
    @(posedge clk) disable iff (srst)
      !en_s |=> ##2 (high_side_gate == 3'h0);
  endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("gates active while disabled");

  property p_fast_align_all;
    @(posedge clk) disable iff (srst)
      fa_s ##1 (phase_en == $past(phase_en)) |=>
      ((high_side_gate | ~$past(phase_en)) == 3'h7);
  endproperty
  a_fast_align_all: assert property (p_fast_align_all)
    else $error("active phase not forced on by fast-align trip");

  property p_dem_both_off;
    @(posedge clk) disable iff (srst)
      (dem_off[0] && !pulse[0] && phase_en[0]) |=>
      (!high_side_gate[0] && !low_side_gate[0]);
  endproperty
  a_dem_both_off: assert property (p_dem_both_off)
    else $error("gate on after zero current in diode emulation");
endmodule

// File: rtl/phase_timer.sv
// Switching-interval counter giving staggered phase start pulses
`timescale 1ns/1ps
module phase_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic [11:0] period,
  input wire logic [1:0] phases,
  // Phase interval starts
  output logic [2:0] start
);
  logic [11:0] count;
  logic [11:0] third;
  logic [11:0] half;

  assign third = 12'((period + 12'h002) / 12'h003);
  assign half = 12'(period >> 1);

  // Interval clock at the strap frequency
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      count <= 12'h000;
    end else if (count >= period - 12'h001) begin
      count <= 12'h000;
    end else begin
      count <= count + 12'h001;
    end
  end

  // Even offsets; a third apart for three phases, half for two
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      start <= 3'h0;
    end else begin
      start[0] <= (count == 12'h000);
      if (phases == pwm_ctrl_pkg::PHASE_CNT_3) begin
        start[1] <= (count == third);
        start[2] <= (count == 12'(third << 1));
      end else begin
        start[1] <= (count == half);
        start[2] <= 1'b0;
      end
    end
  end
endmodule

// File: shared/pwm_ctrl_pkg.sv
// Constants and types for the multiphase pwm and power-state control
// What this block does
// - Hold output_good low until soft-start has completed.
// - Pull output_good low on voltage window fault, overcurrent or disable.
// - Release output_good after fixed delay from soft-start end, voltage good.
// - power_state_low_n high gives normal state, all phases continuous.
// - power_state_low_n low runs phase 1 only, diode emulation per option.
// - power_state_low_n high again resumes normal multiphase operation.
// - host_reset_n low forces normal state whatever power_state_low_n says.
// - Wait 50ms after host_reset_n rises before low-power entry.
// - Soft-start and reference transitions ignore power_state_low_n.
// - Sample power_state_low_n again only after successful completion.
// - Stagger active phases evenly across the switching interval.
// - Three phases start one third of a cycle apart.
// - Pulse interval comes from internal clock at strap frequency.
// - Pulse goes high at first crossing, low at the next one.
// - High pulse drives high side gate on, low side off; low reverses.
// - At most one rising edge per phase per switching interval, except when a fast-align trip forces the phase on.
// - Fast-align trip forces every active phase on together.
// - Three phases by default; strapped third_sense_neg gives two phases.
// - ramp_strap picks low-side supply: ground 5.75V, supply 7.75V.
// - Enable low stops all operation; high lets it begin.
// - Diode emulation turns both gates off at zero current for the cycle.
package pwm_ctrl_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int HOLDOFF_MS = 50;
  localparam int HOLDOFF_CYCLES = CLK_HZ / 1000 * HOLDOFF_MS;
  localparam int GOOD_DELAY_US = 100;
  localparam int GOOD_DELAY_CYCLES = CLK_HZ / 1000000 * GOOD_DELAY_US;
  localparam int PERIOD_W = 12;
  localparam int CNT_W = 22;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = 12'h003;
  localparam logic [1:0] PHASE_CNT_3 = 2'h3;
  localparam logic [1:0] PHASE_CNT_2 = 2'h2;
  typedef enum {ST_OFF, ST_NORMAL, ST_LOW} power_state_t;
endpackage

// File: testbench/proc_stage_model.sv
// Processor state pins and power stage model
`timescale 1ns/1ps
module proc_stage_model (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic want_low,
  input wire logic want_rst,
  // Gate commands
  input wire logic [2:0] high_side_gate,
  input wire logic [2:0] low_side_gate,
  // Pins back to the device
  output logic power_state_low_n,
  output logic host_reset_n,
  output logic [2:0] zero_current
);
  logic [3:0] amps [3] = '{4'h0, 4'h0, 4'h0};
  // Static levels, moved only on request
  always @(posedge clk) begin
    power_state_low_n <= ~want_low;
    host_reset_n <= ~want_rst;
  end
  // Current builds with high side, decays with low side
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (high_side_gate[i])
        amps[i] <= 4'hF;
      else if (low_side_gate[i] && amps[i] != 4'h0)
        amps[i] <= amps[i] - 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++)
      zero_current[i] = (amps[i] == 4'h0);
  end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the multiphase pwm and power-state control
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic enable = 1'b0;
  logic third_sense_neg = 1'b0;
  logic ramp_strap = 1'b0;
  logic [11:0] frequency_strap = 12'h01E;
  logic dem_variant = 1'b1;
  logic soft_start_done = 1'b0;
  logic ref_transition = 1'b0;
  logic voltage_in_window = 1'b1;
  logic overcurrent = 1'b0;
  logic [2:0] error_above_ramp = 3'h0;
  logic fast_align_input = 1'b0;
  logic want_low = 1'b0;
  logic want_rst = 1'b0;
  logic tog = 1'b0;
  logic power_state_low_n, host_reset_n, low_side_supply_reduce;
  logic low_side_supply_high, output_good_out, output_good_oe;
  logic low_power_active;
  logic [2:0] zero_current, high_side_gate, low_side_gate, hs_q;
  logic [1:0] active_phases;
  int err_total = 0;
  int check_count = 0;
  int tick = 0;
  int off_n = 0;
  int rise_t [3] = '{0, 0, 0};
  int rise_n [3] = '{0, 0, 0};

  always #12.5 clk = ~clk;

  multiphase_pwm_power_state_ctrl multiphase_pwm_power_state_ctrl_i (
    .clk(clk), .srst(srst), .enable(enable),
    .third_sense_neg(third_sense_neg), .ramp_strap(ramp_strap),
    .frequency_strap(frequency_strap), .dem_variant(dem_variant),
    .power_state_low_n(power_state_low_n), .host_reset_n(host_reset_n),
    .soft_start_done(soft_start_done), .ref_transition(ref_transition),
    .voltage_in_window(voltage_in_window), .overcurrent(overcurrent),
    .error_above_ramp(error_above_ramp), .zero_current(zero_current),
    .fast_align_input(fast_align_input),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
    .low_side_supply_reduce(low_side_supply_reduce),
    .low_side_supply_high(low_side_supply_high),
    .output_good_out(output_good_out), .output_good_oe(output_good_oe),
    .low_power_active(low_power_active), .active_phases(active_phases));

  proc_stage_model proc_stage_model_i (
    .clk(clk), .want_low(want_low), .want_rst(want_rst),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
    .power_state_low_n(power_state_low_n), .host_reset_n(host_reset_n),
    .zero_current(zero_current));

  // Toggling comparator gives a crossing every cycle
  always @(posedge clk)
    error_above_ramp <= tog ? ~error_above_ramp : 3'h0;

  // Rise times, overlap and diode-emulation watch, off the driving edge
  always @(negedge clk) begin
    tick++;
    for (int i = 0; i < 3; i++) begin
      if (high_side_gate[i] === 1'b1 && hs_q[i] !== 1'b1) begin
        rise_t[i] = tick;
        rise_n[i]++;
      end
    end
    hs_q = high_side_gate;
    `CHK("gate_overlap", 3'h0, high_side_gate & low_side_gate)
    if (low_power_active === 1'b1 && high_side_gate[0] === 1'b0 &&
        low_side_gate[0] === 1'b0)
      off_n++;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait; a miss ends the run
  task automatic wait_lp(input logic v);
    int k;
    k = 0;
    @(negedge clk);
    while (low_power_active !== v && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK("low_power_wait", v, low_power_active)
    if (low_power_active !== v)
      complete_run();
  endtask

  task automatic stagger(input int per, input int sp);
    int d;
    rise_n = '{0, 0, 0};
    cyc(3 * per);
    @(negedge clk);
    d = (rise_t[1] - rise_t[0] + 4 * per) % per;
    `CHK("spacing", 1'b1, d >= sp - 1 && d <= sp + 1)
    `CHK("one_rise", 1'b1, rise_n[0] >= 2 && rise_n[0] <= 4)
  endtask

  initial begin
    cyc(20);
    srst <= 1'b0;
    @(negedge clk);
    `CHK("gates_rst", 3'h0, high_side_gate)
    `CHK("good_rst", 1'b1, output_good_oe)
    `CHK("phases_rst", 2'h3, active_phases)
    `CHK("good_pin", 1'b0, output_good_out)
    cyc(1);
    enable <= 1'b1;
    want_low <= 1'b1;
    cyc(50);
    @(negedge clk);
    `CHK("lp_softstart", 1'b0, low_power_active)
    `CHK("good_softstart", 1'b1, output_good_oe)
    cyc(1);
    soft_start_done <= 1'b1;
    wait_lp(1'b1);
    cyc(3900);
    @(negedge clk);
    `CHK("good_early", 1'b1, output_good_oe)
    `CHK("lp_phases", 2'h0, high_side_gate[2:1])
    `CHK("lp_reduce", 1'b1, low_side_supply_reduce)
    `CHK("supply_low", 1'b0, low_side_supply_high)
    cyc(200);
    @(negedge clk);
    `CHK("good_late", 1'b0, output_good_oe)
    `CHK("dem_off", 1'b1, off_n > 0)
    cyc(1);
    want_low <= 1'b0;
    tog <= 1'b1;
    wait_lp(1'b0);
    stagger(30, 10);
    cyc(1);
    tog <= 1'b0;
    fast_align_input <= 1'b1;
    cyc(8);
    @(negedge clk);
    `CHK("fast_align", 3'h7, high_side_gate)
    cyc(1);
    fast_align_input <= 1'b0;
    overcurrent <= 1'b1;
    cyc(5);
    @(negedge clk);
    `CHK("good_overcurrent", 1'b1, output_good_oe)
    cyc(1);
    overcurrent <= 1'b0;
    ref_transition <= 1'b1;
    want_low <= 1'b1;
    dem_variant <= 1'b0;
    cyc(50);
    @(negedge clk);
    `CHK("lp_reftrans", 1'b0, low_power_active)
    cyc(1);
    ref_transition <= 1'b0;
    wait_lp(1'b1);
    cyc(2);
    @(negedge clk);
    `CHK("ccm_reduce", 1'b0, low_side_supply_reduce)
    `CHK("ccm_low_side", 1'b1, low_side_gate[0])
    cyc(1);
    want_rst <= 1'b1;
    wait_lp(1'b0);
    cyc(1);
    want_rst <= 1'b0;
    cyc(2000);
    @(negedge clk);
    `CHK("lp_holdoff", 1'b0, low_power_active)
    cyc(1);
    enable <= 1'b0;
    cyc(6);
    @(negedge clk);
    `CHK("good_disabled", 1'b1, output_good_oe)
    `CHK("gates_disabled", 3'h0, high_side_gate)
    cyc(1);
    third_sense_neg <= 1'b1;
    ramp_strap <= 1'b1;
    want_low <= 1'b0;
    tog <= 1'b1;
    cyc(4);
    enable <= 1'b1;
    cyc(10);
    @(negedge clk);
    `CHK("phases_two", 2'h2, active_phases)
    `CHK("supply_high", 1'b1, low_side_supply_high)
    stagger(30, 15);
    `CHK("third_idle", 1'b1, rise_n[2] == 0)
    complete_run();
  end
endmodule
